//--- rtl/serial_unit.sv
// serial_unit: asynchronous serial frame transmitter with a parity-checking receiver
// assumes all inputs synchronous to clk; pins resolved outside from o/oe_n pairs
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// first-in first-out buffer with valid/ready on both sides
module fifo_buffer #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 32
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // filling side
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   // draining side
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready,
   // synchronous flush
   input wire logic flush
);
   localparam int unsigned AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];  // storage
   logic [AW:0] wr_q;  // write pointer with wrap bit
   logic [AW:0] rd_q;  // read pointer with wrap bit

   // full when pointers differ only in the wrap bit
   assign in_ready = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
   assign out_valid = (wr_q != rd_q);
   assign out_data = mem[rd_q[AW-1:0]];

   // storage write
   always_ff @(posedge clk)
   begin
      if (in_valid && in_ready)
      begin
         mem[wr_q[AW-1:0]] <= in_data;
      end
   end

   // pointer update
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wr_q <= '0;
         rd_q <= '0;
      end
      else if (flush)
      begin
         wr_q <= '0;
         rd_q <= '0;
      end
      else
      begin
         if (in_valid && in_ready)
         begin
            wr_q <= wr_q + 1'b1;
         end
         if (out_valid && out_ready)
         begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end
endmodule : fifo_buffer

////////////////////////////////////////////////////////////////////////////////
// top of the serial unit
module serial_unit
   import serial_unit_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // configuration
   input wire mode_cfg_t mode_cfg,
   input wire pin_cfg_t pin_cfg,
   input wire logic [7:0] baud_divisor,
   // transmit data from software
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   // transmit status
   output logic tx_busy,
   output logic tx_complete_irq,
   // receive results
   output rx_result_t rx_result,
   output logic rx_valid,
   // transmit pin
   output logic serial_out_pin_o,
   output logic serial_out_pin_oe_n,
   // receive pin
   input wire logic serial_in_pin_i
);

   /////////////////////////////////////////////////////////////////////////////
   // declarations
   logic powered;          // unit powered
   logic tx_on;            // transmitter running
   logic rx_on;            // receiver running
   logic [1:0] par_sel;    // parity code
   logic [3:0] char_len;   // 7 or 8
   logic par_present;      // frame has a parity position
   logic [7:0] buf_data;   // head of transmit buffer
   logic buf_valid;        // buffer holds a byte
   logic buf_take;         // hand-off into shifter
   tx_state_t tx_state_q;  // transmitter state
   logic [11:0] shifter_q; // transmit shifter, bit 0 on the line
   logic [3:0] bits_left_q;// bits still to send
   logic [8:0] tx_cnt_q;   // bit period counter
   logic bit_tick;         // end of one bit period
   logic line_q;           // serial waveform before inversion
   logic serial_wave;      // waveform after inversion
   logic tx_pin_serial;    // pin in serial function
   logic [11:0] frame;     // assembled frame
   logic [3:0] frame_bits; // its length
   logic rx_in;            // internal receive input
   rx_state_t rx_state_q;  // receiver state
   logic [8:0] rx_cnt_q;   // receive period counter
   logic [9:0] rx_bits_q;  // sampled bits after start
   logic [3:0] rx_idx_q;   // next sample index
   logic [3:0] rx_need;    // samples per frame after start

   /////////////////////////////////////////////////////////////////////////////
   // configuration decode
   assign powered = mode_cfg.interface_power_enable;
   assign tx_on = powered && mode_cfg.transmit_enable_bit;
   assign rx_on = powered && mode_cfg.receive_enable_bit;
   assign par_sel = {mode_cfg.parity_select_high, mode_cfg.parity_select_low};
   assign char_len = mode_cfg.char_length_select ? CHAR_LEN_8 : CHAR_LEN_7;
   assign par_present = (par_sel != PAR_NONE);

   /////////////////////////////////////////////////////////////////////////////
   // transmit buffer; drains only into an idle enabled transmitter
   assign buf_take = buf_valid && tx_on && (tx_state_q == TX_IDLE);

   fifo_buffer #(
      .WIDTH(TX_FIFO_WIDTH),
      .DEPTH(TX_FIFO_DEPTH)
   ) u_tx_fifo (
      .clk(clk),
      .rst(rst),
      .in_data(tx_data),
      .in_valid(tx_valid),
      .in_ready(tx_ready),
      .out_data(buf_data),
      .out_valid(buf_valid),
      .out_ready(buf_take),
      .flush(!tx_on)
   );

   /////////////////////////////////////////////////////////////////////////////
   // frame assembly: start, ordered characters, parity, stop ones
   always_comb
   begin
      logic ones;
      ones = ^(buf_data & (mode_cfg.char_length_select ? 8'hff : 8'h7f));
      frame = '1;
      frame[0] = 1'b0;
      for (int i = 0; i < CHAR_MAX; i++)
      begin
         if (i < int'(char_len))
         begin
            // lsb first or mirrored within the character width
            frame[1+i] = mode_cfg.bit_order_select ? buf_data[i]
                                                   : buf_data[int'(char_len)-1-i];
         end
      end
      // parity at position after the last character bit
      unique case (par_sel)
         PAR_EVEN: frame[char_len+4'h1] = ones;
         PAR_ODD:  frame[char_len+4'h1] = !ones;
         PAR_ZERO: frame[char_len+4'h1] = 1'b0;
         PAR_NONE: frame[char_len+4'h1] = 1'b1;   // stop
      endcase
      // start + chars + parity + stops
      frame_bits = 4'h1 + char_len + {3'h0, par_present}
                 + (mode_cfg.stop_length_select ? 4'h2 : 4'h1);
   end

   /////////////////////////////////////////////////////////////////////////////
   // bit period divider: two counts of the divisor per bit
   assign bit_tick = (tx_state_q == TX_SHIFT) && (tx_cnt_q == {baud_divisor, 1'b0} - 9'h1);

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         tx_cnt_q <= '0;
      end
      else if (!tx_on || (tx_state_q == TX_IDLE) || bit_tick)
      begin
         tx_cnt_q <= '0;
      end
      else
      begin
         tx_cnt_q <= tx_cnt_q + 9'h1;
      end
   end

   /////////////////////////////////////////////////////////////////////////////
   // transmit sequencer and shifter
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         tx_state_q <= TX_IDLE;
         shifter_q <= '1;
         bits_left_q <= '0;
         line_q <= LINE_IDLE;
      end
      else if (!tx_on)
      begin
         // disabled transmitter is held in reset
         tx_state_q <= TX_IDLE;
         shifter_q <= '1;
         bits_left_q <= '0;
         line_q <= LINE_IDLE;
      end
      else
      begin
         unique case (tx_state_q)
            TX_IDLE:
            begin
               if (buf_take)
               begin
                  // copy buffer into shifter, start bit on the line
                  shifter_q <= {1'b1, frame[11:1]};
                  line_q <= frame[0];
                  bits_left_q <= frame_bits;
                  tx_state_q <= TX_SHIFT;
               end
            end
            TX_SHIFT:
            begin
               if (bit_tick)
               begin
                  if (bits_left_q == 4'h1)
                  begin
                     line_q <= LINE_IDLE;
                     tx_state_q <= TX_IDLE;
                  end
                  else
                  begin
                     line_q <= shifter_q[0];
                     shifter_q <= {1'b1, shifter_q[11:1]};
                  end
                  bits_left_q <= bits_left_q - 4'h1;
               end
            end
         endcase
      end
   end

   // completion pulse as the last stop bit period ends
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         tx_complete_irq <= 1'b0;
      end
      else
      begin
         tx_complete_irq <= tx_on && bit_tick && (bits_left_q == 4'h1);
      end
   end

   assign tx_busy = (tx_state_q == TX_SHIFT);

   /////////////////////////////////////////////////////////////////////////////
   // transmit pin: serial function or plain port
   assign serial_wave = tx_on ? (line_q ^ mode_cfg.tx_line_invert) : LINE_IDLE;
   assign tx_pin_serial = tx_on && !pin_cfg.out_pin_direction && pin_cfg.out_pin_latch;
   assign serial_out_pin_o = tx_pin_serial ? serial_wave : pin_cfg.out_pin_latch;
   assign serial_out_pin_oe_n = pin_cfg.out_pin_direction;

   /////////////////////////////////////////////////////////////////////////////
   // receive input: forced high unless the pin serves reception
   assign rx_in = (rx_on && pin_cfg.in_pin_direction) ? serial_in_pin_i : 1'b1;
   assign rx_need = char_len + {3'h0, par_present} + 4'h1;

   /////////////////////////////////////////////////////////////////////////////
   // receive sequencer: start check at mid bit, then one sample per bit
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rx_state_q <= RX_IDLE;
         rx_cnt_q <= '0;
         rx_idx_q <= '0;
         rx_bits_q <= '0;
      end
      else if (!rx_on)
      begin
         rx_state_q <= RX_IDLE;
         rx_cnt_q <= '0;
         rx_idx_q <= '0;
      end
      else
      begin
         unique case (rx_state_q)
            RX_IDLE:
            begin
               rx_cnt_q <= '0;
               rx_idx_q <= '0;
               if (!rx_in)
               begin
                  rx_state_q <= RX_START;
               end
            end
            RX_START:
            begin
               // half a bit later the line must still be low
               if (rx_cnt_q == {1'b0, baud_divisor} - 9'h1)
               begin
                  rx_cnt_q <= '0;
                  rx_state_q <= rx_in ? RX_IDLE : RX_BITS;
               end
               else
               begin
                  rx_cnt_q <= rx_cnt_q + 9'h1;
               end
            end
            RX_BITS:
            begin
               if (rx_cnt_q == {baud_divisor, 1'b0} - 9'h1)
               begin
                  rx_cnt_q <= '0;
                  rx_bits_q[rx_idx_q] <= rx_in;
                  rx_idx_q <= rx_idx_q + 4'h1;
                  if (rx_idx_q == rx_need - 4'h1)
                  begin
                     rx_state_q <= RX_IDLE;
                  end
               end
               else
               begin
                  rx_cnt_q <= rx_cnt_q + 9'h1;
               end
            end
            default:
            begin
               rx_state_q <= RX_IDLE;
            end
         endcase
      end
   end

   /////////////////////////////////////////////////////////////////////////////
   // receive result: reorder, check parity and stop once the stop bit is in
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rx_result <= '0;
         rx_valid <= 1'b0;
      end
      else
      begin
         rx_valid <= 1'b0;
         // sequencer has just returned to idle with every sample taken
         if (rx_on && (rx_state_q == RX_IDLE) && (rx_idx_q == rx_need)
             && (rx_cnt_q == 9'h0))
         begin
            logic [7:0] d;
            logic ones;
            d = DATA_RESET;
            for (int i = 0; i < CHAR_MAX; i++)
            begin
               if (i < int'(char_len))
               begin
                  d[i] = mode_cfg.bit_order_select ? rx_bits_q[i]
                                                   : rx_bits_q[int'(char_len)-1-i];
               end
            end
            ones = (^d) ^ rx_bits_q[char_len];
            rx_result.data <= d;
            unique case (par_sel)
               PAR_EVEN: rx_result.parity_error <= ones;
               PAR_ODD:  rx_result.parity_error <= !ones;
               PAR_ZERO: rx_result.parity_error <= 1'b0;
               PAR_NONE: rx_result.parity_error <= 1'b0;
            endcase
            rx_result.framing_error <= !rx_bits_q[rx_need-4'h1];
            rx_valid <= 1'b1;
         end
      end
   end

   /////////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // helper: bit periods counted within a frame
   logic [3:0] ticks_q;
   logic [3:0] nbits_q;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ticks_q <= '0;
         nbits_q <= '0;
      end
      else if (buf_take)
      begin
         ticks_q <= '0;
         nbits_q <= frame_bits;
      end
      else if (bit_tick)
      begin
         ticks_q <= ticks_q + 4'h1;
      end
   end

   sequence s_load;
      (tx_state_q == TX_IDLE) && buf_take ##1 (tx_state_q == TX_SHIFT);
   endsequence

   sequence s_last_bit;
      bit_tick && (bits_left_q == 4'h1) && tx_on;
   endsequence

   a_start_bit_low: assert property (s_load |-> !line_q)
      else $error("frame did not open with a low start bit");

   a_frame_length: assert property (s_last_bit |=> tx_complete_irq && (ticks_q == nbits_q))
      else $error("frame length differs from configured bit count");

   a_complete_idle: assert property (tx_complete_irq |-> (tx_state_q == TX_IDLE) && line_q)
      else $error("completion pulse without idle line");

   a_disable_reset: assert property (!tx_on |=> (tx_state_q == TX_IDLE) && !tx_complete_irq)
      else $error("transmitter not reset by disable");

   a_bit_stable: assert property ((tx_state_q == TX_SHIFT) && !bit_tick && tx_on |=> $stable(line_q))
      else $error("line changed inside a bit period");

   a_unpowered_high: assert property (!powered |-> serial_wave && rx_in)
      else $error("unpowered unit not holding lines high");

   a_port_mode: assert property (!tx_pin_serial |-> serial_out_pin_o == pin_cfg.out_pin_latch)
      else $error("pin not acting as plain port");

   a_no_parity_err: assert property (rx_valid && !(par_sel[1]) |-> !rx_result.parity_error)
      else $error("parity error reported without parity check");

   a_idle_wait: assert property ((tx_state_q == TX_IDLE) && !buf_valid |=> tx_state_q == TX_IDLE)
      else $error("transmitter started without buffered data");

endmodule : serial_unit

//--- rtl/serial_unit_pkg.sv
// serial_unit_pkg: shared types and constants of the serial frame unit
// assumes a single 25 MHz clock and plain configuration ports, no bus
package serial_unit_pkg;

   // clock rate, kept for reference of bit timing
   localparam int unsigned CLK_PERIOD_NS = 40;

   // parity select codes {parity_select_high, parity_select_low}
   localparam logic [1:0] PAR_NONE = 2'h0;
   localparam logic [1:0] PAR_ZERO = 2'h1;
   localparam logic [1:0] PAR_ODD = 2'h2;
   localparam logic [1:0] PAR_EVEN = 2'h3;

   // frame geometry
   localparam int unsigned CHAR_MAX = 8;
   localparam int unsigned FRAME_MAX = 12;
   localparam logic [3:0] CHAR_LEN_7 = 4'h7;
   localparam logic [3:0] CHAR_LEN_8 = 4'h8;

   // transmit buffering ahead of the shifter
   localparam int unsigned TX_FIFO_DEPTH = 32;
   localparam int unsigned TX_FIFO_WIDTH = 8;

   // reset values
   localparam logic LINE_IDLE = 1'b1;
   localparam logic [7:0] DATA_RESET = 8'h00;

   // mode and control bits as software sets them
   typedef struct packed {
      logic interface_power_enable;  // unit powered
      logic transmit_enable_bit;     // transmitter enabled
      logic receive_enable_bit;      // receiver enabled
      logic parity_select_high;      // parity code, upper bit
      logic parity_select_low;       // parity code, lower bit
      logic char_length_select;      // 1: eight bits, 0: seven
      logic stop_length_select;      // 1: two stop bits, 0: one
      logic bit_order_select;        // 1: lsb first, 0: msb first
      logic tx_line_invert;          // complement the transmit waveform
   } mode_cfg_t;

   // port pin settings of both pins
   typedef struct packed {
      logic out_pin_direction;  // 0: output, 1: input
      logic out_pin_latch;      // port output latch
      logic in_pin_direction;   // 1: input
   } pin_cfg_t;

   // received character with its status
   typedef struct packed {
      logic [7:0] data;
      logic parity_error;
      logic framing_error;
   } rx_result_t;

   // transmitter states
   typedef enum logic [1:0] {
      TX_IDLE = 2'b01,
      TX_SHIFT = 2'b10
   } tx_state_t;

   // receiver states
   typedef enum logic [2:0] {
      RX_IDLE = 3'b001,
      RX_START = 3'b010,
      RX_BITS = 3'b100
   } rx_state_t;

endpackage : serial_unit_pkg

//--- verification/line_peer.sv
// line_peer: far-end serial transceiver on the two serial wires
// assumes the unit's clk and a bit period of 2*div clk cycles
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
module line_peer (
   // clock and bit timing
   input wire logic clk,
   input wire logic [7:0] div,
   // serial wires
   input wire logic line_in,
   output logic line_out
);
   // receive wire rests high between frames
   initial line_out = 1'b1;

   // catch n bits from the start edge, sampled mid-bit
   task automatic catch_frame(input int n, input logic inv, output logic [11:0] b,
      output int waited);
      b = '0;
      waited = 0;
      while (((line_in ^ inv) !== 1'b0) && waited < 2000)
      begin
         @(posedge clk);
         waited++;
      end
      repeat (div) @(posedge clk);
      for (int i = 0; i < n; i++)
      begin
         if (i > 0)
            repeat (2 * div) @(posedge clk);
         b[i] = line_in ^ inv;
      end
   endtask : catch_frame

   // send n bits, one bit period each, then rest high
   task automatic send_frame(input logic [11:0] b, input int n);
      for (int i = 0; i < n; i++)
      begin
         line_out <= b[i];
         repeat (2 * div) @(posedge clk);
      end
      line_out <= 1'b1;
   endtask : send_frame

endmodule : line_peer

//--- verification/testbench.sv
// testbench: self-checking bench of the serial unit with a far-end peer
// assumes 25 MHz clk, bit period 2*baud_divisor, pull-up on the transmit wire
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
module testbench
   import serial_unit_pkg::*;
;
   localparam logic [7:0] DIV = 8'h08;  // smallest legal divisor
   // design connections
   logic clk;
   logic rst;
   mode_cfg_t mode_cfg;
   pin_cfg_t pin_cfg;
   logic [7:0] tx_data;
   logic tx_valid;
   logic tx_ready;
   logic tx_busy;
   logic tx_complete_irq;
   rx_result_t rx_result;
   logic rx_valid;
   logic serial_out_pin_o;
   logic serial_out_pin_oe_n;
   logic rx_wire;
   logic tx_wire;  // resolved wire with pull-up
   int n_fail;
   int samples_checked;

   assign tx_wire = serial_out_pin_oe_n ? 1'b1 : serial_out_pin_o;

   serial_unit serial_unit_inst (.clk(clk), .rst(rst), .mode_cfg(mode_cfg), .pin_cfg(pin_cfg),
      .baud_divisor(DIV), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .tx_busy(tx_busy), .tx_complete_irq(tx_complete_irq), .rx_result(rx_result),
      .rx_valid(rx_valid), .serial_out_pin_o(serial_out_pin_o),
      .serial_out_pin_oe_n(serial_out_pin_oe_n), .serial_in_pin_i(rx_wire));

   line_peer line_peer_inst (.clk(clk), .div(DIV), .line_in(tx_wire), .line_out(rx_wire));

   // free-running clock
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////
   // compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // verdict and end of run
   task automatic wrap_up();
      $display("compares %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : wrap_up

   // a used-up wait ends the run
   task automatic bound_hit(input int k, input int lim);
      if (k >= lim)
      begin
         n_fail++;
         wrap_up();
      end
   endtask : bound_hit

   // expected line bits in time order, bit 0 first
   function automatic logic [11:0] frame_of(input logic [7:0] d, input logic [1:0] par,
      input logic cl8, input logic sl2, input logic lsb, output int n);
      logic [11:0] b;
      int nc;
      logic ones;
      b = '0;
      nc = cl8 ? 8 : 7;
      ones = cl8 ? ^d : ^d[6:0];
      n = 1;
      for (int i = 0; i < nc; i++)
      begin
         b[n] = lsb ? d[i] : d[nc - 1 - i];
         n++;
      end
      if (par != PAR_NONE)
      begin
         b[n] = (par == PAR_EVEN) ? ones : ((par == PAR_ODD) ? ~ones : 1'b0);
         n++;
      end
      b[n] = 1'b1;
      b[n + 1] = sl2;
      n = n + 1 + int'(sl2);
      return b;
   endfunction : frame_of

   ////////////////////////////////////////////////////////////////////////////
   // idle levels, pin ownership, abort by disable
   task automatic idle_and_pins();
      @(posedge clk);
      check(16'(tx_wire), 16'h1);
      mode_cfg <= 9'h100;
      repeat (2) @(posedge clk);
      check(16'(tx_wire), 16'h1);
      mode_cfg <= 9'h180;
      tx_data <= 8'h00;
      tx_valid <= 1'b1;
      @(posedge clk);
      tx_valid <= 1'b0;
      repeat (5 * DIV) @(posedge clk);
      check({tx_busy, tx_wire}, 16'h2);
      mode_cfg <= 9'h100;
      repeat (2) @(posedge clk);
      check({tx_busy, tx_wire}, 16'h1);
      mode_cfg <= 9'h180;
      repeat (60) @(posedge clk);
      check({tx_busy, tx_wire}, 16'h1);
      pin_cfg <= 3'b001;
      repeat (2) @(posedge clk);
      check({serial_out_pin_oe_n, serial_out_pin_o}, 16'h0);
      pin_cfg <= 3'b111;
      repeat (2) @(posedge clk);
      check(16'(serial_out_pin_oe_n), 16'h1);
      pin_cfg <= 3'b011;
   endtask : idle_and_pins

   // one frame: {data, parity, eight, two stops, lsb first, invert}
   task automatic tx_case(input logic [13:0] t);
      logic [11:0] exp;
      logic [11:0] got;
      int n;
      int k;
      exp = frame_of(t[13:6], t[5:4], t[3], t[2], t[1], n);
      mode_cfg <= {3'b101, t[5:0]};
      @(posedge clk);
      mode_cfg <= {3'b111, t[5:0]};
      @(posedge clk);
      tx_data <= t[13:6];
      tx_valid <= 1'b1;
      fork
         line_peer_inst.catch_frame(n, t[0], got, k);
         begin
            @(posedge clk);
            tx_valid <= 1'b0;
         end
      join
      bound_hit(k, 2000);
      check(16'(got), 16'(exp));
      k = 0;
      while (tx_complete_irq !== 1'b1 && k < 100)
      begin
         @(posedge clk);
         k++;
      end
      bound_hit(k, 100);
      check(16'(k >= DIV - 1 && k <= DIV + 3), 16'h1);
      check({tx_busy, tx_wire ^ t[0]}, 16'h1);
   endtask : tx_case

   // receive one frame, parity intact or broken, stop bit intact or held low
   task automatic rx_case(input logic [1:0] par, input logic bad, input logic nostop);
      logic [11:0] b;
      int n;
      int k;
      b = frame_of(8'ha6, par, 1'b1, 1'b0, 1'b1, n);
      if (bad && par != PAR_NONE)
         b[9] = ~b[9];
      if (nostop)
         b[n - 1] = 1'b0;
      mode_cfg <= {3'b101, par, 4'b1010};
      @(posedge clk);
      k = 0;
      fork
         line_peer_inst.send_frame(b, n);
         while (rx_valid !== 1'b1 && k < 400)
         begin
            @(posedge clk);
            k++;
         end
      join
      bound_hit(k, 400);
      check(16'(rx_result), {6'h0, 8'ha6, bad & par[1], nostop});
   endtask : rx_case

   // fill the queue until refused, then drain while the shifter stalls it
   task automatic fifo_case();
      int acc;
      int irqs;
      acc = 0;
      irqs = 0;
      mode_cfg <= {3'b111, PAR_NONE, 4'b1010};
      @(posedge clk);
      tx_valid <= 1'b1;
      for (int i = 0; i < 40; i++)
      begin
         @(posedge clk);
         if (tx_ready === 1'b1)
            acc++;
         tx_data <= 8'(acc);
      end
      tx_valid <= 1'b0;
      check(16'(acc), 16'(TX_FIFO_DEPTH + 1));
      for (int i = 0; i < 7000; i++)
      begin
         @(posedge clk);
         if (tx_complete_irq === 1'b1)
            irqs++;
      end
      check(16'(irqs), 16'(TX_FIFO_DEPTH + 1));
      check({tx_ready, tx_busy}, 16'h2);
   endtask : fifo_case

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      n_fail = 0;
      samples_checked = 0;
      rst = 1'b1;
      mode_cfg = '0;
      pin_cfg = 3'b011;
      tx_data = 8'h00;
      tx_valid = 1'b0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      idle_and_pins();
      tx_case({8'h55, PAR_EVEN, 4'b1010});
      tx_case({8'h55, PAR_EVEN, 4'b1001});
      tx_case({8'h36, PAR_ODD, 4'b0110});
      tx_case({8'h87, PAR_NONE, 4'b1010});
      tx_case({8'hc3, PAR_ZERO, 4'b0101});
      tx_case({8'h07, PAR_ODD, 4'b1100});
      tx_case({8'h81, PAR_EVEN, 4'b0011});
      for (int p = 0; p < 4; p++)
      begin
         rx_case(2'(p), 1'b0, 1'b0);
         rx_case(2'(p), 1'b1, 1'b0);
      end
      rx_case(PAR_ODD, 1'b0, 1'b1);
      fifo_case();
      wrap_up();
   end

endmodule : testbench
